//--- pkg/dvo_cfg.svh
// Offsets, field positions, reset values and divider taps of the square-wave divider output.
`ifndef DVO_CFG_SVH
`define DVO_CFG_SVH

`define DVO_ADDR_W 8
`define DVO_DATA_W 8
`define DVO_CTRL_OFFSET 8'h38
`define DVO_EN_BIT 2
`define DVO_SEL_LSB 0
`define DVO_SEL_MSB 1
`define DVO_CTRL_RESET 8'h00
`define DVO_GEAR_CNT_W 12
`define DVO_LOW_CNT_W 5
`define DVO_GEAR_TOP_TAP 4'hb
`define DVO_LOW_TOP_TAP 4'h4
`define DVO_SEL_RESERVED_LOW 2'h3

`endif

//--- pkg/dvo_pkg.sv
// Types shared by the square-wave divider output block.
package dvo_pkg;

  // Decoded control register contents.
  typedef struct packed {
    logic en;
    logic [1:0] sel;
  } dvo_ctrl_t;

  // System mode indications from the mode controller.
  typedef struct packed {
    logic slow_modes;
    logic low_freq_source_select;
    logic deep_mode;
  } dvo_mode_t;

endpackage

//--- verilog/dvo_top.sv
// Square-wave divider output: control register, free-running dividers and the output pin.
`timescale 1ns/100ps
`include "dvo_cfg.svh"

// Function
// [RULE_01] Output is a square wave, about half duty.
// [RULE_02] Gear source taps divide by 4096 down to 512.
// [RULE_03] Low source taps divide by 32, 16, 8.
// [RULE_04] Enable set puts the wave on pin.
// [RULE_05] Enable clear holds pin high.
// [RULE_06] Deep mode entry clears enable, keeps select.
// [RULE_07] Control bits seven to three read zero.
// [RULE_08] Dividers run free regardless of enable.
// [RULE_09] Last period at disable may be short.
// [RULE_10] Synchronised low clock may make frequency jitter.
// [RULE_11] Mode change may disturb frequency briefly.
// [RULE_12] Reset clears enable and select, pin high.
module dvo_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [`DVO_ADDR_W-1:0] reg_addr,
  input wire logic [`DVO_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`DVO_DATA_W-1:0] reg_rdata,
  input wire logic low_frequency_clock,
  input wire dvo_pkg::dvo_mode_t mode,
  output logic square_wave_pin_n
);

  // Picks one bit of a divider chain; the top tap is the slowest output.
  function automatic logic tap_pick(input logic [11:0] cnt, input logic [3:0] top,
                                    input logic [1:0] sel);
    logic [3:0] idx;
    idx = top - {2'h0, sel};
    tap_pick = cnt[idx];
  endfunction

  dvo_pkg::dvo_ctrl_t ctrl_r;
  logic [`DVO_GEAR_CNT_W-1:0] gear_cnt_r;
  logic [`DVO_LOW_CNT_W-1:0] low_cnt_r;
  logic low_sync1_r;
  logic low_sync2_r;
  logic low_prev_r;
  logic deep_prev_r;
  logic [`DVO_DATA_W-1:0] rdata_r;
  logic pin_n_r;
  logic wr_hit;
  logic rd_hit;
  logic deep_entry;
  logic low_edge;
  logic use_low;
  logic gear_tap;
  logic low_tap;
  logic tap;

  // Address decode for the single control register.
  assign wr_hit = reg_wr && (reg_addr == `DVO_CTRL_OFFSET);
  assign rd_hit = reg_rd && (reg_addr == `DVO_CTRL_OFFSET);

  // Entry into stop or deep idle/sleep is the rising edge of the mode level.
  assign deep_entry = mode.deep_mode && !deep_prev_r;

  // Control register; the hardware clear on deep entry wins over a software write.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_r <= '0; // RULE_12
    end else begin
      if (wr_hit) begin
        ctrl_r.en <= reg_wdata[`DVO_EN_BIT];
        ctrl_r.sel <= reg_wdata[`DVO_SEL_MSB:`DVO_SEL_LSB];
      end
      if (deep_entry) begin
        ctrl_r.en <= 1'b0; // RULE_06
      end
    end
  end

  // Deep mode edge detector.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      deep_prev_r <= 1'b0;
    end else begin
      deep_prev_r <= mode.deep_mode;
    end
  end

  // Read data stand for one cycle after the strobe; other addresses read zero.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_r <= `DVO_CTRL_RESET;
    end else if (rd_hit) begin
      rdata_r <= {5'h00, ctrl_r.en, ctrl_r.sel}; // RULE_07
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // Gear clock chain counts every cycle, so enabling never realigns it.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      gear_cnt_r <= '0;
    end else begin
      gear_cnt_r <= gear_cnt_r + 12'h001; // RULE_08
    end
  end

  // The low-frequency clock is resynchronised here, which costs up to a cycle of jitter.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      low_sync1_r <= 1'b0;
      low_sync2_r <= 1'b0;
      low_prev_r <= 1'b0;
    end else begin
      low_sync1_r <= low_frequency_clock;
      low_sync2_r <= low_sync1_r; // RULE_10
      low_prev_r <= low_sync2_r;
    end
  end

  assign low_edge = low_sync2_r && !low_prev_r;

  // Low-frequency chain advances on each rising edge of the synchronised clock.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      low_cnt_r <= '0;
    end else if (low_edge) begin
      low_cnt_r <= low_cnt_r + 5'h01; // RULE_08
    end
  end

  // Source choice follows the mode level directly, so a mode switch may glitch the period.
  assign use_low = mode.slow_modes || mode.low_freq_source_select; // RULE_11
  assign gear_tap = tap_pick(gear_cnt_r, `DVO_GEAR_TOP_TAP, ctrl_r.sel); // RULE_02
  assign low_tap = (ctrl_r.sel == `DVO_SEL_RESERVED_LOW) ? 1'b0 :
                   tap_pick({7'h00, low_cnt_r}, `DVO_LOW_TOP_TAP, ctrl_r.sel); // RULE_03
  assign tap = use_low ? low_tap : gear_tap; // RULE_01

  // Active-low pin; a disable cuts the current period short at once.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_n_r <= 1'b1; // RULE_12
    end else if (ctrl_r.en) begin
      pin_n_r <= !tap; // RULE_04
    end else begin
      pin_n_r <= 1'b1; // RULE_05 RULE_09
    end
  end

  assign reg_rdata = rdata_r;
  assign square_wave_pin_n = pin_n_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Reset release leaves the control register cleared and the pin high.
  property p_reset_vals;
    $fell(rst) |-> (ctrl_r == '0) && pin_n_r;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("state not cleared by reset"); // RULE_12

  property p_disabled_high;
    !ctrl_r.en |=> pin_n_r;
  endproperty
  a_disabled_high: assert property (p_disabled_high) else $error("pin low while disabled"); // RULE_05

  property p_enabled_follows;
    ctrl_r.en |=> (pin_n_r == !$past(tap));
  endproperty
  a_enabled_follows: assert property (p_enabled_follows) else $error("pin not following tap"); // RULE_04

  sequence s_deep_entry;
    $rose(mode.deep_mode);
  endsequence

  property p_deep_clear;
    s_deep_entry |=> !ctrl_r.en ##1 pin_n_r;
  endproperty
  a_deep_clear: assert property (p_deep_clear) else $error("deep entry left output on"); // RULE_06

  property p_deep_keep_sel;
    s_deep_entry and !wr_hit |=> ctrl_r.sel == $past(ctrl_r.sel);
  endproperty
  a_deep_keep_sel: assert property (p_deep_keep_sel) else $error("select lost on deep entry"); // RULE_06

  property p_read_zero;
    rd_hit |=> reg_rdata[7:3] == 5'h00 && reg_rdata[2:0] == $past({ctrl_r.en, ctrl_r.sel});
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("bad control readback"); // RULE_07

  property p_chain_runs;
    !ctrl_r.en |=> gear_cnt_r == $past(gear_cnt_r) + 12'h001;
  endproperty
  a_chain_runs: assert property (p_chain_runs) else $error("gear chain stalled"); // RULE_08

  // A select or source change moves the tap by itself, so only steady settings are judged.
  property p_gear_fast;
    !use_low && ctrl_r.sel == 2'h3 && $stable(ctrl_r.sel) && $stable(use_low) &&
      $changed(gear_tap) |-> gear_cnt_r[7:0] == 8'h00;
  endproperty
  a_gear_fast: assert property (p_gear_fast) else $error("gear tap period wrong"); // RULE_02

  property p_low_reserved;
    use_low && ctrl_r.sel == 2'h3 && ctrl_r.en |=> pin_n_r;
  endproperty
  a_low_reserved: assert property (p_low_reserved) else $error("reserved low code toggles"); // RULE_03

  property p_write_takes;
    wr_hit && !deep_entry |=> ctrl_r == $past({reg_wdata[2], reg_wdata[1:0]});
  endproperty
  a_write_takes: assert property (p_write_takes) else $error("control write lost"); // RULE_04

  // Read data fall back to zero once the strobe has gone.
  property p_rdata_idle;
    !rd_hit |=> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data left standing"); // RULE_07

  // Read data and both chains leave reset cleared.
  property p_reset_rdata;
    $fell(rst) |-> reg_rdata == 8'h00 && gear_cnt_r == 12'h000 && low_cnt_r == 5'h00;
  endproperty
  a_reset_rdata: assert property (p_reset_rdata) else $error("chain not cleared"); // RULE_12

  // Slowest gear tap only moves when the lower eleven bits wrap.
  property p_gear_sel0;
    !use_low && ctrl_r.sel == 2'h0 && $stable(ctrl_r.sel) && $stable(use_low) &&
      $changed(gear_tap) |-> gear_cnt_r[10:0] == 11'h000;
  endproperty
  a_gear_sel0: assert property (p_gear_sel0) else $error("gear tap 0 period wrong"); // RULE_02

  // Second gear tap moves when the lower ten bits wrap.
  property p_gear_sel1;
    !use_low && ctrl_r.sel == 2'h1 && $stable(ctrl_r.sel) && $stable(use_low) &&
      $changed(gear_tap) |-> gear_cnt_r[9:0] == 10'h000;
  endproperty
  a_gear_sel1: assert property (p_gear_sel1) else $error("gear tap 1 period wrong"); // RULE_02

  // Third gear tap moves when the lower nine bits wrap.
  property p_gear_sel2;
    !use_low && ctrl_r.sel == 2'h2 && $stable(ctrl_r.sel) && $stable(use_low) &&
      $changed(gear_tap) |-> gear_cnt_r[8:0] == 9'h000;
  endproperty
  a_gear_sel2: assert property (p_gear_sel2) else $error("gear tap 2 period wrong"); // RULE_02

  // Slowest low tap moves when the lower four bits wrap.
  property p_low_sel0;
    use_low && ctrl_r.sel == 2'h0 && $stable(ctrl_r.sel) && $stable(use_low) &&
      $changed(low_tap) |-> low_cnt_r[3:0] == 4'h0;
  endproperty
  a_low_sel0: assert property (p_low_sel0) else $error("low tap 0 period wrong"); // RULE_03

  // Middle low tap moves when the lower three bits wrap.
  property p_low_sel1;
    use_low && ctrl_r.sel == 2'h1 && $stable(ctrl_r.sel) && $stable(use_low) &&
      $changed(low_tap) |-> low_cnt_r[2:0] == 3'h0;
  endproperty
  a_low_sel1: assert property (p_low_sel1) else $error("low tap 1 period wrong"); // RULE_03

  // Fastest low tap moves when the lower two bits wrap.
  property p_low_sel2;
    use_low && ctrl_r.sel == 2'h2 && $stable(ctrl_r.sel) && $stable(use_low) &&
      $changed(low_tap) |-> low_cnt_r[1:0] == 2'h0;
  endproperty
  a_low_sel2: assert property (p_low_sel2) else $error("low tap 2 period wrong"); // RULE_03

  // The reserved low code never reaches the pin.
  property p_low_reserved_tap;
    use_low && ctrl_r.sel == `DVO_SEL_RESERVED_LOW |-> !low_tap;
  endproperty
  a_low_reserved_tap: assert property (p_low_reserved_tap) else $error("reserved tap live"); // RULE_03

  // Each synchronised low edge advances the low chain by one.
  property p_low_step;
    low_edge |=> low_cnt_r == $past(low_cnt_r) + 5'h01;
  endproperty
  a_low_step: assert property (p_low_step) else $error("low chain missed an edge"); // RULE_08

  // Without an edge the low chain holds.
  property p_low_hold;
    !low_edge |=> $stable(low_cnt_r);
  endproperty
  a_low_hold: assert property (p_low_hold) else $error("low chain moved without edge"); // RULE_08

  // A synchronised edge lasts one cycle, else the chain would count twice.
  property p_low_edge_single;
    low_edge |=> !low_edge;
  endproperty
  a_low_edge_single: assert property (p_low_edge_single) else $error("low edge too long"); // RULE_10

  // The gear chain wraps to zero and keeps running.
  property p_gear_wrap;
    gear_cnt_r == 12'hfff |=> gear_cnt_r == 12'h000;
  endproperty
  a_gear_wrap: assert property (p_gear_wrap) else $error("gear chain did not wrap"); // RULE_08

  // Only a mapped write or a deep entry may touch the control register.
  property p_ctrl_stable;
    !wr_hit && !deep_entry |=> $stable(ctrl_r);
  endproperty
  a_ctrl_stable: assert property (p_ctrl_stable) else $error("control changed by itself"); // RULE_07

  // A disable forces the pin high on the next edge, cutting the period.
  property p_disable_cut;
    $fell(ctrl_r.en) |=> pin_n_r;
  endproperty
  a_disable_cut: assert property (p_disable_cut) else $error("pin low after disable"); // RULE_09

  // On the low source the pin follows the synchronised tap.
  property p_low_follows;
    ctrl_r.en && use_low |=> pin_n_r == !$past(low_tap);
  endproperty
  a_low_follows: assert property (p_low_follows) else $error("pin not on low tap"); // RULE_10

  // On the gear source the pin follows the gear tap, even right after a mode switch.
  property p_gear_follows;
    ctrl_r.en && !use_low |=> pin_n_r == !$past(gear_tap);
  endproperty
  a_gear_follows: assert property (p_gear_follows) else $error("pin not on gear tap"); // RULE_11

  // A write racing a deep entry keeps its select but loses its enable.
  property p_deep_write_race;
    deep_entry && wr_hit |=> !ctrl_r.en && ctrl_r.sel == $past(reg_wdata[1:0]);
  endproperty
  a_deep_write_race: assert property (p_deep_write_race) else $error("deep race wrong"); // RULE_06

  // Only the entry clears the enable; staying in the deep level does not.
  property p_deep_level_no_clear;
    mode.deep_mode && deep_prev_r && wr_hit |=> ctrl_r.en == $past(reg_wdata[2]);
  endproperty
  a_deep_level_no_clear: assert property (p_deep_level_no_clear) else $error("level cleared"); // RULE_06

  // A write always lands in the select field.
  property p_select_write;
    wr_hit |=> ctrl_r.sel == $past(reg_wdata[1:0]);
  endproperty
  a_select_write: assert property (p_select_write) else $error("select write lost"); // RULE_02

  // A write with the enable bit clear turns the output off.
  property p_enable_clear_write;
    wr_hit && !reg_wdata[`DVO_EN_BIT] |=> !ctrl_r.en;
  endproperty
  a_enable_clear_write: assert property (p_enable_clear_write) else $error("enable stuck"); // RULE_05

  // Enabling takes two steps: the bit lands, then the pin starts to follow the tap.
  sequence s_enable_write;
    wr_hit && reg_wdata[`DVO_EN_BIT] && !deep_entry;
  endsequence

  sequence s_wave_on;
    ctrl_r.en ##1 (pin_n_r == !$past(tap));
  endsequence

  property p_enable_path;
    s_enable_write |=> s_wave_on;
  endproperty
  a_enable_path: assert property (p_enable_path) else $error("enable did not start wave"); // RULE_04

endmodule

//--- verif/dvo_load.sv
// Buzzer load model: records the length of the last low and high phase of the pin.
`timescale 1ns/100ps
module dvo_load (
  input wire logic core_clk,
  input wire logic pin_n,
  output logic [15:0] lo_len,
  output logic [15:0] hi_len
);
  logic [15:0] run_r;
  logic last_r;
  // A buzzer only listens, so this model never drives anything back.
  always_ff @(posedge core_clk) begin
    last_r <= pin_n;
    if (pin_n != last_r) begin
      run_r <= 16'h0001;
      if (last_r) begin
        hi_len <= run_r;
      end else begin
        lo_len <= run_r;
      end
    end else begin
      run_r <= run_r + 16'h0001;
    end
  end
endmodule

//--- verif/dvo_top_tb_top.sv
// Self-checking bench for the square-wave divider output driving a buzzer load.
`timescale 1ns/100ps
module dvo_top_tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] ad = 8'h00;
  logic [7:0] wd = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [2:0] lfc = 3'h0;
  dvo_pkg::dvo_mode_t mode = '0;
  logic [7:0] rdat;
  logic [7:0] got;
  logic pin_n;
  logic [15:0] lo_len;
  logic [15:0] hi_len;
  int err_total = 0;
  int comparisons = 0;
  dvo_top dvo_top_i (.core_clk(core_clk), .rst(rst), .reg_addr(ad), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .low_frequency_clock(lfc[2]),
    .mode(mode), .square_wave_pin_n(pin_n));
  dvo_load dvo_load_i (.core_clk(core_clk), .pin_n(pin_n), .lo_len(lo_len),
    .hi_len(hi_len));
  // Core clock, 10 ns period.
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  // Slow clock at one eighth of the core rate, so a low tap is easy to predict.
  always @(posedge core_clk) begin
    lfc <= lfc + 3'h1;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One write or read cycle; read data are taken in the cycle after the strobe.
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    wr <= w;
    rd <= !w;
    ad <= a;
    wd <= d;
    @(posedge core_clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 got = rdat;
  endtask
  // Samples off the edge, after a short settling span, that the pin stays high.
  task automatic quiet(input string nm, input int n);
    int lows = 0;
    #31;
    repeat (n) begin
      #10;
      lows += (pin_n !== 1'b1);
    end
    chk(nm, 16'h0000, lows[15:0]);
  endtask
  // Waits several periods, since the first one after a change may be short.
  task automatic tone(input logic [7:0] c, input int half);
    bus(1'b1, 8'h38, c);
    repeat (6 * half + 40) @(posedge core_clk);
    chk("low phase", half[15:0], lo_len);
    chk("high phase", half[15:0], hi_len);
  endtask
  task automatic t_reset;
    chk("pin", 16'h0001, {15'h0, pin_n});
    bus(1'b0, 8'h38, 8'h00);
    chk("ctrl", 16'h0000, {8'h00, got});
    @(posedge core_clk);
    #1 chk("rdata idle", 16'h0000, {8'h00, rdat});
  endtask
  task automatic t_regs;
    bus(1'b1, 8'h38, 8'hfb);
    bus(1'b1, 8'h39, 8'h07);
    bus(1'b0, 8'h38, 8'h00);
    chk("ctrl", 16'h0003, {8'h00, got});
    bus(1'b0, 8'h39, 8'h00);
    chk("unmapped", 16'h0000, {8'h00, got});
    quiet("idle pin", 300);
  endtask
  task automatic t_gear;
    for (int s = 0; s < 4; s++) begin
      tone(8'h04 | 8'(s), 2048 >> s);
    end
    bus(1'b1, 8'h38, 8'h00);
    quiet("off pin", 4200);
  endtask
  task automatic t_deep;
    bus(1'b1, 8'h38, 8'h06);
    @(posedge core_clk);
    mode.deep_mode <= 1'b1;
    quiet("deep pin", 2100);
    bus(1'b0, 8'h38, 8'h00);
    chk("deep ctrl", 16'h0002, {8'h00, got});
    @(posedge core_clk);
    mode.deep_mode <= 1'b0;
  endtask
  task automatic t_low;
    @(posedge core_clk);
    mode.slow_modes <= 1'b1;
    for (int s = 0; s < 3; s++) begin
      tone(8'h04 | 8'(s), 128 >> s);
    end
    bus(1'b1, 8'h38, 8'h07);
    quiet("reserved", 600);
    @(posedge core_clk);
    mode <= 3'b010;
    tone(8'h04, 128);
  endtask
  task automatic give_verdict;
    $display("Comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_gear();
    t_deep();
    t_low();
    give_verdict();
  end
  // Cuts a hang short well past the longest expected run.
  initial begin
    #600000;
    err_total++;
    give_verdict();
  end
endmodule
